// File: dv/wdp_watchdog_checker.sv
`default_nettype none

// ---------------------------------------------------------------
// watchdog port checker
// ---------------------------------------------------------------
module wdp_watchdog_checker #(
	parameter int BASE_CYCLES = wdp_pkg::WDT_BASE_CYCLES
) (
	// clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// apb
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0]  pstrb,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr,
	// system side
	input wire logic        device_reset,
	input wire logic        asleep,
	input wire logic        irq
);
	timeunit 1ns;
	timeprecision 100ps;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	// accepted command writes
	wire logic acc_cmd;
	wire logic acc_sleep;
	assign acc_cmd   = psel && penable && pready && pwrite && pstrb[0] && (paddr == 32'(wdp_pkg::OFS_CMD));
	assign acc_sleep = acc_cmd && pwdata[wdp_pkg::CMD_SLEEP_BIT];

	// cycles since the last accepted clear or sleep command, or since the last device reset pulse
	logic [31:0] since;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			since <= 32'h0;
		end else if ((acc_cmd && (pwdata[1:0] != 2'h0)) || device_reset) begin
			since <= 32'h0;
		end else if (since != 32'hFFFFFFFF) begin
			since <= since + 32'h1;
		end
	end

	ready_after_setup_a: assert property (psel && !penable |=> pready) else $error("no pready after setup");
	ready_single_a: assert property (pready |=> !pready) else $error("pready held too long");
	unmapped_err_a: assert property (pready && (paddr[31:8] != 24'h0) |-> pslverr && (prdata == 32'h0))
		else $error("unmapped access not refused");
	config_read_a: assert property (pready && !pwrite && (paddr == 32'h0) |-> !pslverr && (prdata == 32'h0))
		else $error("config readback not zero");
	reset_pulse_a: assert property ($rose(device_reset) |=> !device_reset)
		else $error("device reset not one cycle");
	min_period_a: assert property (device_reset |-> since >= 32'(BASE_CYCLES))
		else $error("time-out before a full period");
	sleep_entry_a: assert property (acc_sleep |=> (asleep or ##1 device_reset))
		else $error("sleep command not taken");
	sleep_cause_a: assert property ($rose(asleep) |-> $past(acc_sleep))
		else $error("sleep without command");
	wake_reset_a: assert property ($fell(asleep) |=> device_reset)
		else $error("wake without reset");
	awake_reset_a: assert property (device_reset |-> !asleep)
		else $error("asleep during reset pulse");
endmodule

bind wdp_watchdog wdp_watchdog_checker #(.BASE_CYCLES(BASE_CYCLES)) wdp_watchdog_checker_inst (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
	.device_reset(device_reset), .asleep(asleep), .irq(irq)
);

`default_nettype wire

// File: dv/wdp_watchdog_tb.sv
`default_nettype none

// ---------------------------------------------------------------
// watchdog testbench
// ---------------------------------------------------------------
module wdp_watchdog_tb;
	timeunit 1ns;
	timeprecision 100ps;

	localparam int          BASE   = 20;
	localparam logic [31:0] A_CFG  = 32'(wdp_pkg::OFS_CONFIG);
	localparam logic [31:0] A_CMD  = 32'(wdp_pkg::OFS_CMD);
	localparam logic [31:0] A_STAT = 32'(wdp_pkg::OFS_STATUS);
	localparam logic [31:0] A_MASK = 32'(wdp_pkg::OFS_MASK);
	localparam logic [31:0] A_CNT  = 32'(wdp_pkg::OFS_COUNT);

	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, device_reset, asleep, irq, err;
	logic [31:0] paddr, pwdata, prdata, rd;
	logic [3:0]  pstrb;
	int          n_mismatch, comparisons, i;

	wdp_watchdog #(.BASE_CYCLES(BASE)) wdp_watchdog_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.device_reset(device_reset), .asleep(asleep), .irq(irq)
	);

	// free-running clock
	always #50 pclk = ~pclk;

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %0h seen %0h", what, exp, got);
		end
	endtask

	// irq is registered with a lag, so look a few cycles on
	task automatic chk_irq(input logic exp, input string what);
		repeat (3) @(negedge pclk);
		chk(what, {31'h0, exp}, {31'h0, irq});
	endtask

	// one apb transfer; pready, read data and error are taken at the rising edge that ends the access
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		for (k = 0; k < 16; k++) begin
			@(posedge pclk);
			if (pready === 1'b1) break;
		end
		if (k == 16) begin
			n_mismatch++;
			summarize();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// count idle cycles from the last restart up to the reset pulse
	task automatic expect_reset(input int period, input string what);
		int n;
		for (n = 0; n < 5000; n++) begin
			@(negedge pclk);
			if (device_reset === 1'b1) break;
		end
		if (n == 5000) begin
			n_mismatch++;
			summarize();
		end
		chk(what, 32'(period + 1), 32'(n));
		chk("awake at reset", 32'h0, {31'h0, asleep});
	endtask

	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_defaults();
		apb(1'b0, A_CFG, 32'h0);
		chk("config read", 32'h0, rd);
		apb(1'b0, 32'h0000_0140, 32'h0);
		chk("unmapped err", 32'h1, {31'h0, err});
		apb(1'b1, A_CMD, 32'h1);
		expect_reset(BASE * 128, "default period");
		$display("defaults test done");
	endtask

	task automatic t_ratios();
		for (i = 0; i < 8; i++) begin
			apb(1'b1, A_CFG, 32'h08 | 32'(i));
			apb(1'b1, A_CMD, 32'h1);
			expect_reset(BASE << i, "ratio period");
		end
		apb(1'b1, A_CFG, 32'h07);
		apb(1'b1, A_CMD, 32'h1);
		expect_reset(BASE, "unassigned period");
		apb(1'b1, A_CMD, 32'h1);
		expect_reset(BASE * 128, "config reload");
		$display("ratio test done");
	endtask

	// a late clear must also restart the prescaler
	task automatic t_clear();
		apb(1'b1, A_CFG, 32'h09);
		apb(1'b1, A_CMD, 32'h1);
		repeat (BASE + 4) @(posedge pclk);
		apb(1'b1, A_CMD, 32'h1);
		expect_reset(2 * BASE, "late clear period");
		$display("clear test done");
	endtask

	task automatic t_sleep();
		apb(1'b0, A_STAT, 32'h0);
		apb(1'b1, A_CFG, 32'h09);
		apb(1'b1, A_CMD, 32'h1);
		repeat (BASE + 4) @(posedge pclk);
		apb(1'b1, A_CMD, 32'h2);
		@(negedge pclk);
		chk("asleep", 32'h1, {31'h0, asleep});
		// counter view: sleep flag set, prescaler zero, base one cycle past the restart
		apb(1'b0, A_CNT, 32'h0);
		chk("count view", 32'h8000_0001, rd);
		expect_reset(2 * BASE - 3, "sleep period");
		apb(1'b0, A_STAT, 32'h0);
		chk("wake status", 32'h7, rd);
		$display("sleep test done");
	endtask

	task automatic t_irq();
		apb(1'b0, A_STAT, 32'h0);
		apb(1'b1, A_MASK, 32'h1);
		apb(1'b0, A_MASK, 32'h0);
		chk("mask read", 32'h1, rd);
		apb(1'b1, A_CFG, 32'h00);
		apb(1'b1, A_CMD, 32'h1);
		expect_reset(BASE, "irq period");
		chk_irq(1'b1, "irq raised");
		apb(1'b1, A_MASK, 32'h0);
		chk_irq(1'b0, "irq masked");
		apb(1'b1, A_MASK, 32'h1);
		chk_irq(1'b1, "irq unmasked");
		apb(1'b0, A_STAT, 32'h0);
		chk("status", 32'h1, rd);
		chk_irq(1'b0, "irq cleared");
		$display("irq test done");
	endtask

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 32'h0;
		pwdata = 32'h0;
		pstrb = 4'hF;
		n_mismatch = 0;
		comparisons = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_defaults();
		t_ratios();
		t_clear();
		t_sleep();
		t_irq();
		summarize();
	end
endmodule

`default_nettype wire

// File: logic/wdp_pkg.sv
`default_nettype none

// ---------------------------------------------------------------
// watchdog with shared prescaler: constants
// ---------------------------------------------------------------
package wdp_pkg;

	// ---------------------------------------------------------------
	// clock and time-out figures
	// ---------------------------------------------------------------
	localparam int CLK_FREQ_HZ      = 10_000_000;
	localparam int WDT_PERIOD_US    = 18_000;                             // nominal period, no prescaler
	localparam int CYCLES_PER_US    = CLK_FREQ_HZ / 1_000_000;
	localparam int WDT_BASE_CYCLES  = WDT_PERIOD_US * CYCLES_PER_US;      // 180000 cycles
	localparam int BASE_CNT_W       = 24;
	localparam int POST_CNT_W       = 7;                                  // up to 1:128
	localparam int RESET_PULSE_CYCLES = 1;

	// ---------------------------------------------------------------
	// register byte offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] OFS_CONFIG = 8'h00;                            // timer_prescale_config
	localparam logic [7:0] OFS_CMD    = 8'h04;
	localparam logic [7:0] OFS_STATUS = 8'h08;
	localparam logic [7:0] OFS_MASK   = 8'h0C;
	localparam logic [7:0] OFS_COUNT  = 8'h10;
	localparam int         ADDR_W     = 8;

	// ---------------------------------------------------------------
	// configuration register layout
	// ---------------------------------------------------------------
	localparam int         CFG_W          = 8;
	localparam int         CFG_ASSIGN_BIT = 3;                            // prescaler_assign_flag
	localparam int         CFG_RATIO_LSB  = 0;                            // prescale_ratio_bit2..0
	localparam int         CFG_RATIO_W    = 3;
	localparam logic [7:0] CFG_RESET      = 8'hFF;

	// ---------------------------------------------------------------
	// command register bits
	// ---------------------------------------------------------------
	localparam int CMD_CLEAR_BIT = 0;                                     // clear_watchdog_instr
	localparam int CMD_SLEEP_BIT = 1;

	// ---------------------------------------------------------------
	// status and mask layout
	// ---------------------------------------------------------------
	localparam int EV_W         = 3;
	localparam int EV_TIMEOUT   = 0;
	localparam int EV_WAKE      = 1;
	localparam int EV_SLEEP     = 2;
	localparam logic [2:0] MASK_RESET = 3'h0;

	// ---------------------------------------------------------------
	// count register layout
	// ---------------------------------------------------------------
	localparam int CNT_POST_LSB  = 24;
	localparam int CNT_SLEEP_BIT = 31;

	// ---------------------------------------------------------------
	// power states
	// ---------------------------------------------------------------
	typedef enum logic {
		WDP_RUN,
		WDP_SLEEP
	} wdp_power_e;

endpackage

`default_nettype wire

// File: logic/wdp_watchdog.sv
// The implementer's own choices: the register offsets and the APB interface to the registers.
`default_nettype none

// Notes on behaviour
// - without prescaler, the interval from clear to time-out is nominally 18 ms.
// - software assigns the shared prescaler to the watchdog, ratio up to 1:128.
// - counter expiry issues a full device reset.
// - clear-watchdog instruction zeroes the counter and the assigned prescaler.
// - sleep instruction zeroes the counter and the assigned prescaler too.
// - a time-out while asleep wakes the device through a reset.
// - configuration bit 3 is the assignment flag, bits 2..0 the ratio field.
// - configuration loads all ones on every reset, so prescaler max on watchdog.

module wdp_watchdog #(
	parameter int BASE_CYCLES = wdp_pkg::WDT_BASE_CYCLES
) (
	// clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// apb slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	// system side
	output logic             device_reset,
	output logic             asleep,
	output logic             irq
);

	// ---------------------------------------------------------------
	// local constants
	// ---------------------------------------------------------------
	localparam int                           BW        = wdp_pkg::BASE_CNT_W;
	localparam int                           PW        = wdp_pkg::POST_CNT_W;
	localparam int                           EW        = wdp_pkg::EV_W;
	localparam logic [BW-1:0]                BASE_LAST = BW'(BASE_CYCLES - 1);
	localparam logic [PW-1:0]                POST_ONE  = PW'(1);
	localparam logic [BW-1:0]                BASE_ONE  = BW'(1);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [wdp_pkg::CFG_W-1:0] timer_prescale_config;
	logic [BW-1:0]             base_cnt;
	logic [PW-1:0]             post_cnt;
	logic [EW-1:0]             status;
	logic [EW-1:0]             mask;
	wdp_pkg::wdp_power_e       power;
	logic                      rst_pulse;

	// ---------------------------------------------------------------
	// apb decode
	// ---------------------------------------------------------------
	wire logic [7:0] reg_addr;
	wire logic       setup_phase;
	wire logic       access_done;
	wire logic       wr_done;
	wire logic       rd_done;
	wire logic       hit_config;
	wire logic       hit_cmd;
	wire logic       hit_status;
	wire logic       hit_mask;
	wire logic       hit_count;
	wire logic       addr_mapped;

	// address and phase decode
	assign reg_addr    = paddr[7:0];
	assign setup_phase = psel & ~penable;
	assign access_done = psel & penable & pready;
	assign wr_done     = access_done & pwrite;
	assign rd_done     = access_done & ~pwrite;
	assign hit_config  = (reg_addr == wdp_pkg::OFS_CONFIG);
	assign hit_cmd     = (reg_addr == wdp_pkg::OFS_CMD);
	assign hit_status  = (reg_addr == wdp_pkg::OFS_STATUS);
	assign hit_mask    = (reg_addr == wdp_pkg::OFS_MASK);
	assign hit_count   = (reg_addr == wdp_pkg::OFS_COUNT);
	assign addr_mapped = (paddr[31:8] == 24'h000000) &
	                     (hit_config | hit_cmd | hit_status | hit_mask | hit_count);

	// ---------------------------------------------------------------
	// instruction strobes from the command register
	// ---------------------------------------------------------------
	wire logic cmd_write;
	wire logic clear_watchdog_instr;
	wire logic sleep_instr;

	// byte lane 0 must be enabled for a command to count
	assign cmd_write            = wr_done & hit_cmd & addr_mapped & pstrb[0];
	assign clear_watchdog_instr = cmd_write & pwdata[wdp_pkg::CMD_CLEAR_BIT];
	assign sleep_instr          = cmd_write & pwdata[wdp_pkg::CMD_SLEEP_BIT];

	// ---------------------------------------------------------------
	// configuration fields
	// ---------------------------------------------------------------
	wire logic                            prescaler_assign_flag;
	wire logic [wdp_pkg::CFG_RATIO_W-1:0] prescale_ratio;
	wire logic [PW-1:0]                   post_last;

	// field extraction from the configuration register
	assign prescaler_assign_flag = timer_prescale_config[wdp_pkg::CFG_ASSIGN_BIT];
	assign prescale_ratio        = timer_prescale_config[wdp_pkg::CFG_RATIO_LSB +: wdp_pkg::CFG_RATIO_W];
	// ratio n gives 2**n base periods per time-out
	assign post_last             = PW'((POST_ONE << prescale_ratio) - POST_ONE);

	// ---------------------------------------------------------------
	// time base and prescaler stepping
	// ---------------------------------------------------------------
	wire logic base_wrap;
	wire logic post_wrap;
	wire logic timeout;
	wire logic restart;

	// base counter spans one nominal period
	assign base_wrap = (base_cnt == BASE_LAST);
	// prescaler only lengthens the period when assigned
	assign post_wrap = ~prescaler_assign_flag | (post_cnt == post_last);
	assign timeout   = base_wrap & post_wrap;
	// instructions restart counter and the assigned prescaler
	assign restart   = clear_watchdog_instr | sleep_instr;

	// ---------------------------------------------------------------
	// next values of the counters
	// ---------------------------------------------------------------
	logic [BW-1:0] next_base_cnt;
	logic [PW-1:0] next_post_cnt;

	// a time-out resets the device, so counting starts over too
	always_comb begin
		next_base_cnt = base_cnt + BASE_ONE;
		next_post_cnt = post_cnt;
		if (restart || timeout) begin
			next_base_cnt = '0;
			next_post_cnt = '0;
		end else if (base_wrap) begin
			next_base_cnt = '0;
			if (prescaler_assign_flag) begin
				next_post_cnt = post_cnt + POST_ONE;
			end
		end
	end

	// counter registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			base_cnt <= '0;
			post_cnt <= '0;
		end else begin
			base_cnt <= next_base_cnt;
			post_cnt <= next_post_cnt;
		end
	end

	// ---------------------------------------------------------------
	// configuration register
	// ---------------------------------------------------------------
	wire logic cfg_write;

	assign cfg_write = wr_done & hit_config & addr_mapped & pstrb[0];

	// reloads all ones on power-on and on a watchdog reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			timer_prescale_config <= wdp_pkg::CFG_RESET;
		end else if (timeout) begin
			timer_prescale_config <= wdp_pkg::CFG_RESET;
		end else if (cfg_write) begin
			timer_prescale_config <= pwdata[wdp_pkg::CFG_W-1:0];
		end
	end

	// ---------------------------------------------------------------
	// power state
	// ---------------------------------------------------------------
	wdp_pkg::wdp_power_e next_power;

	// sleep is left only by a reset, here the watchdog one
	always_comb begin
		next_power = power;
		unique case (power)
			wdp_pkg::WDP_RUN: begin
				if (sleep_instr && !timeout) begin
					next_power = wdp_pkg::WDP_SLEEP;
				end
			end
			wdp_pkg::WDP_SLEEP: begin
				if (timeout) begin
					next_power = wdp_pkg::WDP_RUN;
				end
			end
		endcase
	end

	// power state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power <= wdp_pkg::WDP_RUN;
		end else begin
			power <= next_power;
		end
	end

	// ---------------------------------------------------------------
	// device reset pulse
	// ---------------------------------------------------------------
	// one cycle per expiry, awake or asleep
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rst_pulse <= 1'b0;
		end else begin
			rst_pulse <= timeout;
		end
	end

	// ---------------------------------------------------------------
	// event status, read-to-clear
	// ---------------------------------------------------------------
	wire logic [EW-1:0] ev_set;
	wire logic          status_read;

	assign ev_set[wdp_pkg::EV_TIMEOUT] = timeout;
	assign ev_set[wdp_pkg::EV_WAKE]    = timeout & (power == wdp_pkg::WDP_SLEEP);
	assign ev_set[wdp_pkg::EV_SLEEP]   = sleep_instr;
	assign status_read                 = rd_done & hit_status & addr_mapped;

	// one sticky bit per event; a new event beats the read clear
	genvar gi;
	generate
		for (gi = 0; gi < EW; gi++) begin : g_status
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					status[gi] <= 1'b0;
				end else if (ev_set[gi]) begin
					status[gi] <= 1'b1;
				end else if (status_read) begin
					status[gi] <= 1'b0;
				end
			end
		end
	endgenerate

	// ---------------------------------------------------------------
	// mask register
	// ---------------------------------------------------------------
	wire logic mask_write;

	assign mask_write = wr_done & hit_mask & addr_mapped & pstrb[0];

	// enables per status bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask <= wdp_pkg::MASK_RESET;
		end else if (mask_write) begin
			mask <= pwdata[EW-1:0];
		end
	end

	// ---------------------------------------------------------------
	// read data selection
	// ---------------------------------------------------------------
	wire logic [31:0] count_word;
	wire logic [31:0] next_rdata;

	// counter view with sleep flag on top
	assign count_word = {(power == wdp_pkg::WDP_SLEEP), post_cnt, base_cnt};
	// configuration is write-only and reads as zero
	assign next_rdata = (!addr_mapped) ? 32'h00000000 :
	                    hit_status     ? {29'h00000000, status} :
	                    hit_mask       ? {29'h00000000, mask} :
	                    hit_count      ? count_word :
	                                     32'h00000000;

	// ---------------------------------------------------------------
	// apb answer: one wait-free access cycle after setup
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			prdata  <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready  <= setup_phase;
			prdata  <= (setup_phase && !pwrite) ? next_rdata : 32'h00000000;
			pslverr <= setup_phase & ~addr_mapped;
		end
	end

	// ---------------------------------------------------------------
	// system outputs
	// ---------------------------------------------------------------
	wire logic next_irq;

	// level while any unmasked status bit is set
	assign next_irq = |(status & mask);

	// registered outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq          <= 1'b0;
			asleep       <= 1'b0;
			device_reset <= 1'b0;
		end else begin
			irq          <= next_irq;
			asleep       <= (next_power == wdp_pkg::WDP_SLEEP);
			device_reset <= rst_pulse;
		end
	end

endmodule

`default_nettype wire
